/* design/backlight_regs_params.svh */
// Register offsets, field positions, reset values and rule summary for the backlight register bank
// Summary of operation
// - Status bits 7 and 6 read zero; writes to them are ignored.
// - Status bits are read-only except the summary error flag, clearable by host.
// - Status bit 3 reads one while backlight is on.
// - Summary flag set by OR of thermal, overcurrent, one-down, two-down; never by bit 3.
// - Bit 4 reads one when one or more channels are faulted out.
// - Bit 5 reads one when two or more channels are faulted out.
// - Enable on then immediately off records no fault.
// - Summary flag stays set after its cause goes away until cleared.
// - Summary flag clears on enable-bit toggle or a written zero.
// - After a clear the flag sets again if the fault persists or recurs.
// - Loss of backlight supply is never reported as a fault.
// - Bit 2 shows input overcurrent, bit 1 shows thermal shutdown, live.
// - Status register resets to all zeros.
// - ID holds one in bit 7, maker code in 6..3, revision in 2..0.
// - ID register is read-only with bit 7 always one.
// - Maker codes 10 to 14 reserved, 15 means none, lower values name vendors.
// - Revision starts at zero and counts up per released silicon.
// - DC level register is read/write, 256 linear codes, changes only DC level.
// - DC level reads back current value and resets to full scale.
// - Setup register picks short threshold or none and boost frequency; resets all ones.
// - Setup bit 1 zero disables short detect; else bit 0 one high, zero low threshold.
// - Setup bit 2 one selects fast boost frequency, zero the slow one.
// - Backlight enable bit turns backlight on at one; defaults to zero.
`ifndef BACKLIGHT_REGS_PARAMS_SVH
`define BACKLIGHT_REGS_PARAMS_SVH

`define OFF_FAULT_AND_STATUS 8'h02
`define OFF_IDENTIFICATION 8'h03
`define OFF_DC_CURRENT_LEVEL 8'h07
`define OFF_PROTECTION_SETUP 8'h08

`define STAT_SUMMARY_BIT 0
`define STAT_THERMAL_BIT 1
`define STAT_OVERCURRENT_BIT 2
`define STAT_BL_ON_BIT 3
`define STAT_ONE_DOWN_BIT 4
`define STAT_MULTI_DOWN_BIT 5

`define SETUP_SC_LEVEL_BIT 0
`define SETUP_SC_ENABLE_BIT 1
`define SETUP_FREQ_BIT 2

`define RST_FAULT_AND_STATUS 8'h00
`define RST_DC_CURRENT_LEVEL 8'hff
`define RST_PROTECTION_SETUP 8'hff
`define ID_FIXED_TOP 1'h1
`define MAKER_CODE_NONE 4'hf

`endif

/* design/backlight_regs_pkg.sv */
// Types shared by the backlight register bank
package backlight_regs_pkg;
  typedef enum logic [1:0] {
    SC_DISABLED = 2'b00,
    SC_LOW = 2'b10,
    SC_HIGH = 2'b11
  } short_mode_t;

  typedef struct packed {
    logic summary;
    logic en_prev;
    logic [7:0] dc_level;
    logic [7:0] setup;
    logic [7:0] rdata;
  } bank_state_t;
endpackage

/* design/fault_summary_if.sv */
// Carrier between the bank and its fault summary unit
`timescale 1ns/1ps
`default_nettype none
interface fault_summary_if;
  logic thermal;
  logic overcurrent;
  logic one_down;
  logic multi_down;
  logic any_fault;
  modport src (output thermal, output overcurrent, output one_down, output multi_down,
    output any_fault);
  modport dst (input thermal, input overcurrent, input one_down, input multi_down,
    input any_fault);
endinterface
`default_nettype wire

/* design/fault_summary.sv */
// Fault condition qualifier and string-down counter
`timescale 1ns/1ps
`default_nettype none
module fault_summary #(
  parameter int CHANNELS = 6
) (
  input wire logic [CHANNELS-1:0] chan_down_i,
  input wire logic thermal_i,
  input wire logic overcurrent_i,
  input wire logic supply_ok_i,
  fault_summary_if.src fs
);
  function automatic logic [3:0] count_ones(input logic [CHANNELS-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < CHANNELS; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  logic [CHANNELS-1:0] chan_down_masked;
  logic [3:0] ndown;

  // Channel drop caused by supply loss is not a fault
  assign chan_down_masked = supply_ok_i ? chan_down_i : '0;
  assign ndown = count_ones(chan_down_masked);
  assign fs.thermal = thermal_i;
  assign fs.overcurrent = overcurrent_i & supply_ok_i;
  assign fs.one_down = ndown >= 4'h1;
  assign fs.multi_down = ndown >= 4'h2;
  assign fs.any_fault = fs.thermal | fs.overcurrent | fs.one_down | fs.multi_down;
endmodule
`default_nettype wire

/* design/backlight_regs.sv */
// Status, identification, DC level and setup registers of the backlight driver
`timescale 1ns/1ps
`default_nettype none
`include "backlight_regs_params.svh"
module backlight_regs #(
  parameter int CHANNELS = 6,
  parameter logic [3:0] MAKER_CODE = `MAKER_CODE_NONE, // Arbitrary value
  parameter logic [2:0] SILICON_REV = 3'h0
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic backlight_enable_bit_i,
  input wire logic backlight_on_i,
  input wire logic [CHANNELS-1:0] chan_down_i,
  input wire logic thermal_i,
  input wire logic overcurrent_i,
  input wire logic supply_ok_i,
  output logic [7:0] dc_level_field_o,
  output backlight_regs_pkg::short_mode_t short_mode_o,
  output logic boost_frequency_select_o
);
  backlight_regs_pkg::bank_state_t s_q;
  backlight_regs_pkg::bank_state_t s_d;
  fault_summary_if fs_if ();
  logic [7:0] status;
  logic [7:0] ident;
  logic clr_write;
  logic clr_toggle;
  logic wr_status;
  logic wr_ident;
  logic wr_dc;
  logic wr_setup;
  logic rd_status;
  logic rd_ident;
  logic rd_dc;
  logic rd_setup;

  // Strobe qualified by a register offset
  function automatic logic bus_hit(input logic en, input logic [7:0] addr,
                                   input logic [7:0] off);
    return en && addr == off;
  endfunction

  assign wr_status = bus_hit(wr_en_i, addr_i, `OFF_FAULT_AND_STATUS);
  assign wr_ident = bus_hit(wr_en_i, addr_i, `OFF_IDENTIFICATION);
  assign wr_dc = bus_hit(wr_en_i, addr_i, `OFF_DC_CURRENT_LEVEL);
  assign wr_setup = bus_hit(wr_en_i, addr_i, `OFF_PROTECTION_SETUP);
  assign rd_status = bus_hit(rd_en_i, addr_i, `OFF_FAULT_AND_STATUS);
  assign rd_ident = bus_hit(rd_en_i, addr_i, `OFF_IDENTIFICATION);
  assign rd_dc = bus_hit(rd_en_i, addr_i, `OFF_DC_CURRENT_LEVEL);
  assign rd_setup = bus_hit(rd_en_i, addr_i, `OFF_PROTECTION_SETUP);

  fault_summary #(.CHANNELS(CHANNELS)) u_fault (
    .chan_down_i(chan_down_i),
    .thermal_i(thermal_i),
    .overcurrent_i(overcurrent_i),
    .supply_ok_i(supply_ok_i),
    .fs(fs_if.src)
  );

  always_comb begin
    status = 8'h00;
    status[`STAT_SUMMARY_BIT] = s_q.summary;
    status[`STAT_THERMAL_BIT] = fs_if.thermal;
    status[`STAT_OVERCURRENT_BIT] = fs_if.overcurrent;
    status[`STAT_BL_ON_BIT] = backlight_on_i;
    status[`STAT_ONE_DOWN_BIT] = fs_if.one_down;
    status[`STAT_MULTI_DOWN_BIT] = fs_if.multi_down;
  end

  assign ident = {`ID_FIXED_TOP, MAKER_CODE, SILICON_REV};
  // Only bit 0 written low clears; other status bits are not writable
  assign clr_write = wr_status && !wdata_i[`STAT_SUMMARY_BIT];
  assign clr_toggle = backlight_enable_bit_i != s_q.en_prev;

  always_comb begin
    s_d = s_q;
    s_d.en_prev = backlight_enable_bit_i;
    // Set wins over clear; quick on/off with no fault leaves flag clear
    if (fs_if.any_fault) begin
      s_d.summary = 1'b1;
    end else if (clr_write || clr_toggle) begin
      s_d.summary = 1'b0;
    end
    if (wr_en_i) begin
      unique case (addr_i)
        `OFF_DC_CURRENT_LEVEL: s_d.dc_level = wdata_i;
        `OFF_PROTECTION_SETUP: s_d.setup = wdata_i;
        default: ;
      endcase
    end
    s_d.rdata = s_q.rdata;
    if (rd_en_i) begin
      unique case (addr_i)
        `OFF_FAULT_AND_STATUS: s_d.rdata = status;
        `OFF_IDENTIFICATION: s_d.rdata = ident;
        `OFF_DC_CURRENT_LEVEL: s_d.rdata = s_q.dc_level;
        `OFF_PROTECTION_SETUP: s_d.rdata = s_q.setup;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q.summary <= 1'b0;
      s_q.en_prev <= 1'b0;
      s_q.dc_level <= `RST_DC_CURRENT_LEVEL;
      s_q.setup <= `RST_PROTECTION_SETUP;
      s_q.rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign dc_level_field_o = s_q.dc_level;
  // Bit 1 low disables detection regardless of bit 0
  assign short_mode_o = s_q.setup[`SETUP_SC_ENABLE_BIT]
    ? (s_q.setup[`SETUP_SC_LEVEL_BIT] ? backlight_regs_pkg::SC_HIGH
                                      : backlight_regs_pkg::SC_LOW)
    : backlight_regs_pkg::SC_DISABLED;
  assign boost_frequency_select_o = s_q.setup[`SETUP_FREQ_BIT];

  a_summary_sets: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    fs_if.any_fault |=> s_q.summary)
    else $error("summary flag not set by fault");

  a_summary_holds: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_q.summary && !clr_write && !clr_toggle |=> s_q.summary)
    else $error("summary flag dropped without clear");

  a_clear_works: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (clr_write || clr_toggle) && !fs_if.any_fault |=> !s_q.summary)
    else $error("summary flag not cleared");

  a_one_no_clear: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_q.summary && wr_status && wdata_i[`STAT_SUMMARY_BIT] && !clr_toggle |=> s_q.summary)
    else $error("writing one cleared summary");

  a_id_top: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_ident |=> rdata_o[7])
    else $error("id top bit not one");

  a_status_reserved: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_status |=> rdata_o[7:6] == 2'b00)
    else $error("reserved status bits nonzero");

  a_multi_implies_one: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    fs_if.multi_down |-> fs_if.one_down)
    else $error("two down without one down");

  a_dc_write: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_dc |=> dc_level_field_o == $past(wdata_i))
    else $error("dc level not written");

  a_short_off: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    !s_q.setup[`SETUP_SC_ENABLE_BIT] |-> short_mode_o == backlight_regs_pkg::SC_DISABLED)
    else $error("short detect not disabled");

  a_supply_loss: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    !supply_ok_i && !thermal_i |-> !fs_if.any_fault)
    else $error("supply loss reported as fault");

  a_id_fields: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_ident |=> rdata_o[6:3] == MAKER_CODE && rdata_o[2:0] == SILICON_REV)
    else $error("id fields wrong");

  a_bl_on_read: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_status |=> rdata_o[`STAT_BL_ON_BIT] == $past(backlight_on_i))
    else $error("backlight on bit wrong");

  a_thermal_read: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_status |=> rdata_o[`STAT_THERMAL_BIT] == $past(thermal_i))
    else $error("thermal bit wrong");

  a_overcurrent_read: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_status |=> rdata_o[`STAT_OVERCURRENT_BIT] == $past(overcurrent_i && supply_ok_i))
    else $error("overcurrent bit wrong");

  a_one_down_read: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_status |=> rdata_o[`STAT_ONE_DOWN_BIT] == $past(supply_ok_i && (|chan_down_i)))
    else $error("one down bit wrong");

  a_summary_read: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_status |=> rdata_o[`STAT_SUMMARY_BIT] == $past(s_q.summary))
    else $error("summary bit readback wrong");

  a_bl_no_set: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    !s_q.summary && !fs_if.any_fault |=> !s_q.summary)
    else $error("summary set without fault");

  a_quick_toggle: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    !s_q.summary && !fs_if.any_fault && clr_toggle |=> !s_q.summary)
    else $error("enable toggle recorded a fault");

  a_set_after_clear: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    (clr_write || clr_toggle) && fs_if.any_fault |=> s_q.summary)
    else $error("persisting fault not set again");

  a_thermal_sets: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    thermal_i |=> s_q.summary)
    else $error("thermal did not set summary");

  a_overcurrent_sets: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    overcurrent_i && supply_ok_i |=> s_q.summary)
    else $error("overcurrent did not set summary");

  a_down_sets: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    supply_ok_i && (|chan_down_i) |=> s_q.summary)
    else $error("string down did not set summary");

  a_supply_mask: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    !supply_ok_i |-> !fs_if.overcurrent && !fs_if.one_down && !fs_if.multi_down)
    else $error("fault shown during supply loss");

  a_one_down_live: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    fs_if.one_down == (supply_ok_i && (|chan_down_i)))
    else $error("one down flag wrong");

  a_multi_down_live: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    fs_if.multi_down == (supply_ok_i && $countones(chan_down_i) > 1))
    else $error("two down flag wrong");

  a_ident_write: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_ident |=> s_q.dc_level == $past(s_q.dc_level) && s_q.setup == $past(s_q.setup))
    else $error("id write changed a register");

  a_setup_write: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_setup |=> s_q.setup == $past(wdata_i))
    else $error("setup not written");

  a_setup_read: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_setup |=> rdata_o == $past(s_q.setup))
    else $error("setup readback wrong");

  a_dc_read: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_dc |=> rdata_o == $past(dc_level_field_o))
    else $error("dc level readback wrong");

  a_dc_only: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_dc |=> s_q.setup == $past(s_q.setup))
    else $error("dc write changed setup");

  a_short_low: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_q.setup[1] && !s_q.setup[0] |-> short_mode_o == backlight_regs_pkg::SC_LOW)
    else $error("low threshold not selected");

  a_short_high: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    s_q.setup[1] && s_q.setup[0] |-> short_mode_o == backlight_regs_pkg::SC_HIGH)
    else $error("high threshold not selected");

  a_freq_select: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_setup |=> boost_frequency_select_o == $past(wdata_i[`SETUP_FREQ_BIT]))
    else $error("boost frequency select wrong");

  a_enable_tracks: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    1'b1 |=> s_q.en_prev == $past(backlight_enable_bit_i))
    else $error("enable reference not tracked");

  a_status_no_write: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_status |=> s_q.dc_level == $past(s_q.dc_level) && s_q.setup == $past(s_q.setup))
    else $error("status write changed a register");

  a_write_zero_clears: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    clr_write && !clr_toggle && !fs_if.any_fault |=> !s_q.summary)
    else $error("written zero did not clear");
endmodule
`default_nettype wire

/* tb/smbus_host_model.sv */
// Host model issuing single byte register writes and reads
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    // Released data shows the inverse, not the old byte
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    // Registered read data stands from the edge after the strobe
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Testbench for the backlight register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end
module tb;
  logic clk = 1'b0, arst_n = 1'b0, wr_en, rd_en, en_bit = 1'b0, bl_on = 1'b0;
  logic thermal = 1'b0, oc = 1'b0, supply_ok = 1'b1, freq;
  logic [7:0] addr, wdata, rdata, dc, v;
  logic [5:0] down = 6'h00;
  backlight_regs_pkg::short_mode_t mode;
  int num_errors = 0, comparisons = 0;
  always #4 clk = ~clk;
  smbus_host_model smbus_host_model_inst (.clk_i(clk), .rdata_i(rdata), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));
  backlight_regs #(.MAKER_CODE(4'h5), .SILICON_REV(3'h2)) backlight_regs_inst (
    .clk_sys_i(clk), .arst_n_i(arst_n), .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata), .backlight_enable_bit_i(en_bit),
    .backlight_on_i(bl_on), .chan_down_i(down), .thermal_i(thermal), .overcurrent_i(oc),
    .supply_ok_i(supply_ok), .dc_level_field_o(dc), .short_mode_o(mode),
    .boost_frequency_select_o(freq));
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    repeat (3) @(posedge clk);
    smbus_host_model_inst.rd(a, v);
    `CHK("rdata", e, v)
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    chk(8'h02, 8'h00);
    chk(8'h07, 8'hff);
    chk(8'h08, 8'hff);
    chk(8'h03, 8'haa);
    chk(8'h10, 8'h00);
    $display("reset values done");
    smbus_host_model_inst.wr(8'h03, 8'h00);
    chk(8'h03, 8'haa);
    smbus_host_model_inst.wr(8'h07, 8'h5a);
    chk(8'h07, 8'h5a);
    `CHK("dc", 8'h5a, dc)
    smbus_host_model_inst.wr(8'h08, 8'hf8);
    chk(8'h08, 8'hf8);
    `CHK("mode", 2'b00, mode)
    `CHK("freq", 1'b0, freq)
    smbus_host_model_inst.wr(8'h08, 8'h02);
    chk(8'h08, 8'h02);
    `CHK("mode", 2'b10, mode)
    smbus_host_model_inst.wr(8'h08, 8'h07);
    chk(8'h08, 8'h07);
    `CHK("mode", 2'b11, mode)
    `CHK("freq", 1'b1, freq)
    $display("config done");
    smbus_host_model_inst.wr(8'h02, 8'hff);
    chk(8'h02, 8'h00);
    bl_on <= 1'b1;
    chk(8'h02, 8'h08);
    thermal <= 1'b1;
    chk(8'h02, 8'h0b);
    thermal <= 1'b0;
    chk(8'h02, 8'h09);
    smbus_host_model_inst.wr(8'h02, 8'hff);
    chk(8'h02, 8'h09);
    smbus_host_model_inst.wr(8'h02, 8'h00);
    chk(8'h02, 8'h08);
    oc <= 1'b1;
    chk(8'h02, 8'h0d);
    smbus_host_model_inst.wr(8'h02, 8'h00);
    chk(8'h02, 8'h0d);
    oc <= 1'b0;
    down <= 6'h04;
    chk(8'h02, 8'h19);
    down <= 6'h21;
    chk(8'h02, 8'h39);
    supply_ok <= 1'b0;
    smbus_host_model_inst.wr(8'h02, 8'h00);
    chk(8'h02, 8'h08);
    down <= 6'h00;
    supply_ok <= 1'b1;
    thermal <= 1'b1;
    repeat (2) @(posedge clk);
    thermal <= 1'b0;
    chk(8'h02, 8'h09);
    en_bit <= 1'b1;
    chk(8'h02, 8'h08);
    en_bit <= 1'b0;
    chk(8'h02, 8'h08);
    // Enable raised and dropped on consecutive edges
    en_bit <= 1'b1;
    @(posedge clk);
    en_bit <= 1'b0;
    chk(8'h02, 8'h08);
    $display("status done");
    end_of_test();
  end
endmodule
`default_nettype wire
